// *** hw/trap_map.vh ***
// Constants and behaviour notes for the trace register access permission checker
// Notes on behaviour
// - Error outcome drops write data; read data is unspecified (we return zero).
// - Memory-mapped Error outcome raises an error response on the memory bus.
// - Coprocessor Error outcome raises an undefined-instruction exception.
// - OK completes; read-only writes dropped; write-only or RAZ reads give zero. The checker applies every OK write
//   except trace-class writes while the powerdown flag is set, and returns the register on every OK read.
// - Writes-ignored outcome drops writes; reads return the register contents.
// - Unpredictable outcome: anything may happen; read value unspecified.
// - Coprocessor access while powered down cannot complete; system decides response.
// - Powerdown flag is main control bit 0; while set trace writes drop.
// - Direct JTAG gives no access to management registers.
// - Direct JTAG cannot reach lock access register; software lock ignored.
// - Direct JTAG gives no access to save/restore mechanism.
// - Direct JTAG cannot reach trace registers while core unpowered.
// - Software debug enable does not affect external debugger accesses.
// - Software debug enable low makes every memory-mapped processor access an Error.
// - Software debug enable does not affect coprocessor accesses.
// - No-power state: unit unpowered, or memory-mapped with enable low.
// - Coprocessor non-privileged state: powered, user mode, access disabled.
// - Debugger access permissions per register class, Error when unpowered.
// - Memory-mapped access permissions per register class, Error when unpowered.
// - Software lock set makes processor memory-mapped trace and management writes ignored.
// - Coprocessor: unpowered not possible, non-privileged Error, else debugger table.
// - Memory-mapped debugger and processor accesses are told apart.
`ifndef TRAP_MAP_VH
`define TRAP_MAP_VH
// Ports
`define TRAP_PORT_DBG      2'h0
`define TRAP_PORT_MEM      2'h1
`define TRAP_PORT_CP       2'h2
`define TRAP_PORT_JTAG     2'h3
// Register classes
`define TRAP_CLS_TRACE     4'h0
`define TRAP_CLS_LSR       4'h1
`define TRAP_CLS_LAR       4'h2
`define TRAP_CLS_PDSR      4'h3
`define TRAP_CLS_OSLSR     4'h4
`define TRAP_CLS_OSLAR     4'h5
`define TRAP_CLS_SSRR      4'h6
`define TRAP_CLS_ID        4'h7
`define TRAP_CLS_MGMT      4'h8
`define TRAP_CLS_RSV_TRACE 4'h9
`define TRAP_CLS_RSV_MGMT  4'hA
// Outcomes
`define TRAP_OUT_OK        3'h0
`define TRAP_OUT_ERR       3'h1
`define TRAP_OUT_NOT_POSSIBLE_OUTCOME     3'h2
`define TRAP_OUT_UNP       3'h3
`define TRAP_OUT_WI        3'h4
`define TRAP_OUT_RAZ       3'h5
`define TRAP_OUT_SBZP      3'h6
// AHB-Lite
`define TRAP_HTRANS_NONSEQ 2'h2
`define TRAP_HSIZE_WORD    3'h2
`define TRAP_HRESP_OKAY    1'b0
`define TRAP_HRESP_ERROR   1'b1
// Window registers
`define TRAP_OFS_CTRL      12'h000
`define TRAP_OFS_REQ       12'h004
`define TRAP_OFS_WDATA     12'h008
`define TRAP_OFS_RESULT    12'h00C
`define TRAP_OFS_RDATA     12'h010
`define TRAP_OFS_MAIN      12'h014
`define TRAP_OFS_REGVAL    12'h018
`define TRAP_MAIN_PD_BIT   0
`define TRAP_MAIN_KEEP     32'h0000_0001
`define TRAP_CTRL_RESET    32'h0000_0000
`endif

// *** hw/trap_checker.v ***
// Trace register access permission checker with AHB-Lite control and status
//
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "trap_map.vh"
module trap_checker (
  input  wire        clk,
  input  wire        reset,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // Access request from the trace unit ports
  input  wire        acc_valid,
  input  wire [1:0]  acc_port,
  input  wire        acc_from_debugger,
  input  wire [3:0]  acc_class,
  input  wire        acc_write,
  input  wire [31:0] acc_wdata,
  input  wire [31:0] acc_reg_value,
  input  wire        unit_powered,
  input  wire        proc_privileged,
  input  wire        coproc_access_enabled,
  input  wire        software_debug_access_enable,
  input  wire        software_lock_set,
  // Decision outputs
  output reg         acc_done,
  output reg  [2:0]  acc_outcome,
  output reg         acc_write_en,
  output reg  [31:0] acc_rdata,
  output reg         mem_bus_error,
  output reg         undef_exception,
  output reg         not_possible,
  output wire        powerdown_flag
);

  reg [31:0] ctrl_r;
  reg [31:0] main_control_reg_r;
  reg [31:0] last_req_r;
  reg [31:0] last_wdata_r;
  reg [31:0] last_rdata_r;
  reg [2:0]  last_out_r;
  reg        sw_pend_r;

  assign powerdown_flag = main_control_reg_r[`TRAP_MAIN_PD_BIT];

  // Classify by port and class, then pick the table entry
  function [2:0] decide;
    input [1:0] port;
    input [3:0] cls;
    input       pwr;
    input       swen;
    input       priv;
    input       cpen;
    input       lock;
    input       wr;
    reg         nopwr;
    begin
      nopwr = !pwr || (port == `TRAP_PORT_MEM && !swen);
      decide = `TRAP_OUT_OK;
      case (port)
        `TRAP_PORT_CP: begin
          if (!pwr) begin
            decide = `TRAP_OUT_NOT_POSSIBLE_OUTCOME;
          end else if (!priv && !cpen) begin
            decide = `TRAP_OUT_ERR;
          end else begin
            case (cls)
              `TRAP_CLS_LSR:       decide = `TRAP_OUT_RAZ;
              `TRAP_CLS_LAR:       decide = `TRAP_OUT_WI;
              `TRAP_CLS_SSRR:      decide = `TRAP_OUT_UNP;
              `TRAP_CLS_RSV_TRACE: decide = `TRAP_OUT_SBZP;
              `TRAP_CLS_RSV_MGMT:  decide = `TRAP_OUT_SBZP;
              default:             decide = `TRAP_OUT_OK;
            endcase
          end
        end
        `TRAP_PORT_JTAG: begin
          if (cls == `TRAP_CLS_TRACE) begin
            decide = pwr ? `TRAP_OUT_OK : `TRAP_OUT_ERR;
          end else if (cls == `TRAP_CLS_RSV_TRACE) begin
            decide = pwr ? `TRAP_OUT_SBZP : `TRAP_OUT_ERR;
          end else begin
            decide = `TRAP_OUT_ERR;
          end
        end
        `TRAP_PORT_MEM: begin
          if (nopwr) begin
            decide = `TRAP_OUT_ERR;
          end else begin
            case (cls)
              `TRAP_CLS_SSRR:      decide = `TRAP_OUT_UNP;
              `TRAP_CLS_RSV_TRACE: decide = `TRAP_OUT_SBZP;
              `TRAP_CLS_RSV_MGMT:  decide = `TRAP_OUT_SBZP;
              `TRAP_CLS_TRACE, `TRAP_CLS_OSLAR, `TRAP_CLS_MGMT:
                decide = lock ? `TRAP_OUT_WI : `TRAP_OUT_OK;
              default:             decide = `TRAP_OUT_OK;
            endcase
          end
        end
        default: begin
          if (nopwr) begin
            decide = `TRAP_OUT_ERR;
          end else begin
            case (cls)
              `TRAP_CLS_LSR:       decide = `TRAP_OUT_RAZ;
              `TRAP_CLS_LAR:       decide = `TRAP_OUT_WI;
              `TRAP_CLS_SSRR:      decide = `TRAP_OUT_UNP;
              `TRAP_CLS_RSV_TRACE: decide = `TRAP_OUT_SBZP;
              `TRAP_CLS_RSV_MGMT:  decide = `TRAP_OUT_SBZP;
              default:             decide = `TRAP_OUT_OK;
            endcase
          end
        end
      endcase
    end
  endfunction

  // Memory-mapped from an external debugger follows the debugger table
  wire [1:0] eff_port = (acc_port == `TRAP_PORT_MEM && acc_from_debugger) ?
                        `TRAP_PORT_DBG : acc_port;
  wire [2:0] out_c = decide(eff_port, acc_class, unit_powered,
                            software_debug_access_enable, proc_privileged,
                            coproc_access_enabled,
                            software_lock_set && acc_port != `TRAP_PORT_JTAG,
                            acc_write);
  wire       pd_drop = powerdown_flag && acc_class == `TRAP_CLS_TRACE;
  wire       wr_ok = acc_write && out_c == `TRAP_OUT_OK && !pd_drop;

  // AHB-Lite: zero wait, always OKAY; registered address phase
  reg        dp_valid_r;
  reg        dp_write_r;
  reg [11:0] dp_addr_r;
  wire       ahb_go = hsel && hready && htrans == `TRAP_HTRANS_NONSEQ;
  assign hreadyout = 1'b1;
  assign hresp     = `TRAP_HRESP_OKAY;

  wire sw_trigger = dp_valid_r && dp_write_r && dp_addr_r == `TRAP_OFS_CTRL && hwdata[0];
  wire req_go     = acc_valid || sw_pend_r;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r  <= 12'h000;
    end else begin
      dp_valid_r <= ahb_go;
      dp_write_r <= hwrite;
      dp_addr_r  <= {haddr[11:2], 2'b00};
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_r             <= `TRAP_CTRL_RESET;
      main_control_reg_r <= `TRAP_MAIN_KEEP;
      last_req_r         <= 32'h0000_0000;
      last_wdata_r       <= 32'h0000_0000;
      last_rdata_r       <= 32'h0000_0000;
      last_out_r         <= `TRAP_OUT_OK;
      sw_pend_r          <= 1'b0;
      acc_done           <= 1'b0;
      acc_outcome        <= `TRAP_OUT_OK;
      acc_write_en       <= 1'b0;
      acc_rdata          <= 32'h0000_0000;
      mem_bus_error      <= 1'b0;
      undef_exception    <= 1'b0;
      not_possible       <= 1'b0;
    end else begin
      sw_pend_r <= sw_trigger;
      if (dp_valid_r && dp_write_r) begin
        case (dp_addr_r)
          `TRAP_OFS_REQ:   last_req_r   <= hwdata;
          `TRAP_OFS_WDATA: last_wdata_r <= hwdata;
          `TRAP_OFS_MAIN:  main_control_reg_r <= hwdata;
          default:         ctrl_r <= ctrl_r;
        endcase
      end
      acc_done        <= acc_valid && out_c != `TRAP_OUT_NOT_POSSIBLE_OUTCOME;
      acc_outcome     <= out_c;
      acc_write_en    <= acc_valid && wr_ok;
      mem_bus_error   <= acc_valid && acc_port == `TRAP_PORT_MEM &&
                         out_c == `TRAP_OUT_ERR;
      undef_exception <= acc_valid && acc_port == `TRAP_PORT_CP &&
                         out_c == `TRAP_OUT_ERR;
      not_possible    <= acc_valid && out_c == `TRAP_OUT_NOT_POSSIBLE_OUTCOME;
      if (out_c == `TRAP_OUT_OK || out_c == `TRAP_OUT_WI) begin
        acc_rdata <= acc_reg_value;
      end else begin
        acc_rdata <= 32'h0000_0000;
      end
      if (req_go) begin
        last_out_r   <= out_c;
        last_rdata_r <= (out_c == `TRAP_OUT_OK || out_c == `TRAP_OUT_WI) ?
                        acc_reg_value : 32'h0000_0000;
      end
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (ahb_go && !hwrite) begin
      case ({haddr[11:2], 2'b00})
        `TRAP_OFS_CTRL:   hrdata <= ctrl_r;
        `TRAP_OFS_REQ:    hrdata <= last_req_r;
        `TRAP_OFS_WDATA:  hrdata <= last_wdata_r;
        `TRAP_OFS_RESULT: hrdata <= {29'h0, last_out_r};
        `TRAP_OFS_RDATA:  hrdata <= last_rdata_r;
        `TRAP_OFS_MAIN:   hrdata <= main_control_reg_r;
        `TRAP_OFS_REGVAL: hrdata <= acc_reg_value;
        default:          hrdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule
`default_nettype wire

// *** tb/trap_sva.sv ***
// Port assertions for the access permission checker
`timescale 1ns/1ps
`default_nettype none
`include "trap_map.vh"
module trap_sva (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       acc_valid,
  input wire logic [1:0] acc_port,
  input wire logic       acc_from_debugger,
  input wire logic [3:0] acc_class,
  input wire logic       acc_write,
  input wire logic       unit_powered,
  input wire logic       proc_privileged,
  input wire logic       coproc_access_enabled,
  input wire logic       software_debug_access_enable,
  input wire logic       software_lock_set,
  input wire logic       acc_done,
  input wire logic [2:0] acc_outcome,
  input wire logic       acc_write_en,
  input wire logic       mem_bus_error,
  input wire logic       undef_exception,
  input wire logic       not_possible
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire cp = acc_valid && acc_port == `TRAP_PORT_CP;
  wire mm = acc_valid && acc_port == `TRAP_PORT_MEM && !acc_from_debugger;
  wire dp = acc_valid && acc_port == `TRAP_PORT_DBG;
  property p_swen; mm && !software_debug_access_enable
    |=> mem_bus_error && !acc_write_en && acc_outcome == `TRAP_OUT_ERR; endproperty
  a_swen: assert property (p_swen) else $error("enable low not refused");
  property p_dbg; dp && unit_powered && acc_class == `TRAP_CLS_TRACE
    |=> acc_done && acc_outcome == `TRAP_OUT_OK; endproperty
  a_dbg: assert property (p_dbg) else $error("debugger trace access failed");
  property p_npos; cp && !unit_powered |=> not_possible && !acc_done; endproperty
  a_npos: assert property (p_npos) else $error("unpowered coproc completed");
  property p_npriv; cp && unit_powered && !proc_privileged && !coproc_access_enabled
    |=> undef_exception; endproperty
  a_npriv: assert property (p_npriv) else $error("no undefined trap");
  property p_undef; undef_exception
    |-> $past(acc_valid) && $past(acc_port) == `TRAP_PORT_CP && acc_outcome == `TRAP_OUT_ERR;
  endproperty
  a_undef: assert property (p_undef) else $error("stray undefined trap");
  property p_berr; mem_bus_error
    |-> $past(acc_valid) && $past(acc_port) == `TRAP_PORT_MEM && acc_outcome == `TRAP_OUT_ERR;
  endproperty
  a_berr: assert property (p_berr) else $error("stray bus error");
  property p_lock; mm && software_debug_access_enable && unit_powered && software_lock_set
    && acc_write && acc_class == `TRAP_CLS_TRACE |=> !acc_write_en; endproperty
  a_lock: assert property (p_lock) else $error("locked write applied");
  property p_jtag; acc_valid && acc_port == `TRAP_PORT_JTAG && acc_class == `TRAP_CLS_MGMT
    |=> !acc_write_en; endproperty
  a_jtag: assert property (p_jtag) else $error("jtag management write applied");
  c_npos: cover property (cp && !unit_powered);
  c_swen: cover property (mm && !software_debug_access_enable);
  c_lock: cover property (mm && software_lock_set && acc_write);
endmodule
`default_nettype wire

// *** tb/trap_reg_model.sv ***
// Register contents seen behind the checker
`timescale 1ns/1ps
`default_nettype none
module trap_reg_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [31:0] wdata,
  input  wire logic        write_en,
  output var  logic [31:0] value
);
  logic [31:0] wdata_r;
  // Nonzero reset so a read-as-zero is visible
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wdata_r <= 32'h0;
      value   <= 32'hA5C3_0F01;
    end else begin
      wdata_r <= wdata;
      if (write_en) begin
        value <= wdata_r;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/trap_checker_tb.sv ***
// Self-checking bench for the access permission checker
`timescale 1ns/1ps
`default_nettype none
`include "trap_map.vh"
module trap_checker_tb;
  logic        clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready;
  logic        acc_valid = 1'b0, acc_write = 1'b0, acc_from_debugger = 1'b0;
  logic        unit_powered = 1'b1, proc_privileged = 1'b1, coproc_access_enabled = 1'b1;
  logic        software_debug_access_enable = 1'b1, software_lock_set = 1'b0;
  logic        hreadyout, hresp, acc_done, acc_write_en, mem_bus_error, undef_exception;
  logic        not_possible, powerdown_flag;
  logic [1:0]  htrans = 2'h0, acc_port = 2'h0;
  logic [2:0]  hsize = 3'h2, acc_outcome;
  logic [3:0]  acc_class = 4'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, acc_wdata = 32'h0, hrdata, acc_rdata;
  logic [31:0] acc_reg_value, rd;
  int          n_mismatch = 0, samples_checked = 0;
  always #10 clk = ~clk;
  assign hready = hreadyout;
  trap_checker dut (
    .clk                          (clk),
    .reset                        (reset),
    .hsel                         (hsel),
    .haddr                        (haddr),
    .htrans                       (htrans),
    .hwrite                       (hwrite),
    .hsize                        (hsize),
    .hwdata                       (hwdata),
    .hready                       (hready),
    .hreadyout                    (hreadyout),
    .hresp                        (hresp),
    .hrdata                       (hrdata),
    .acc_valid                    (acc_valid),
    .acc_port                     (acc_port),
    .acc_from_debugger            (acc_from_debugger),
    .acc_class                    (acc_class),
    .acc_write                    (acc_write),
    .acc_wdata                    (acc_wdata),
    .acc_reg_value                (acc_reg_value),
    .unit_powered                 (unit_powered),
    .proc_privileged              (proc_privileged),
    .coproc_access_enabled        (coproc_access_enabled),
    .software_debug_access_enable (software_debug_access_enable),
    .software_lock_set            (software_lock_set),
    .acc_done                     (acc_done),
    .acc_outcome                  (acc_outcome),
    .acc_write_en                 (acc_write_en),
    .acc_rdata                    (acc_rdata),
    .mem_bus_error                (mem_bus_error),
    .undef_exception              (undef_exception),
    .not_possible                 (not_possible),
    .powerdown_flag               (powerdown_flag)
  );
  trap_reg_model u_regs (.clk, .reset, .wdata(acc_wdata), .write_en(acc_write_en),
                         .value(acc_reg_value));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic edge_rdy;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      if (hreadyout === 1'b1) return;
    end
    chk("hready", 1'b0, 1'b1);
    close_out();
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= `TRAP_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    edge_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    edge_rdy();
    rd = hrdata;
  endtask
  task automatic st(input logic pw, pr, ce, sw, lk);
    @(posedge clk);
    unit_powered <= pw;
    proc_privileged <= pr;
    coproc_access_enabled <= ce;
    software_debug_access_enable <= sw;
    software_lock_set <= lk;
  endtask
  // Outcome unchecked when the expected code is unknown
  task automatic acc(input logic [1:0] p, input logic [3:0] c, input logic w, logic [2:0] eo);
    @(posedge clk);
    acc_valid <= 1'b1;
    acc_port <= p;
    acc_class <= c;
    acc_write <= w;
    acc_wdata <= 32'h1234_5678;
    @(posedge clk);
    acc_valid <= 1'b0;
    #1;
    if (eo !== 3'hX) chk("outcome", acc_outcome, eo);
  endtask
  task automatic t_main;
    chk("pd_rst", powerdown_flag, 1'b1);
    acc(2'h0, 4'h0, 1'b1, 3'hX);
    chk("pd_drop", acc_write_en, 1'b0);
    ahb(1'b1, 32'h14, 32'h0);
    ahb(1'b0, 32'h14, 32'h0);
    chk("main", rd, 32'h0);
    acc(2'h0, 4'h0, 1'b1, 3'h0);
    chk("we", acc_write_en, 1'b1);
    ahb(1'b0, 32'h40, 32'h0);
    chk("unmap", rd, 32'h0);
  endtask
  task automatic t_swen;
    st(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    acc(2'h1, 4'h0, 1'b1, 3'h1);
    chk("berr", mem_bus_error, 1'b1);
    chk("err_we", acc_write_en, 1'b0);
    acc(2'h1, 4'h7, 1'b0, 3'h1);
    chk("err_rd", acc_rdata, 32'h0);
    ahb(1'b0, 32'hC, 32'h0);
    chk("last", rd, 32'h1);
    acc(2'h0, 4'h3, 1'b0, 3'h0);
    acc(2'h2, 4'h4, 1'b0, 3'h0);
  endtask
  task automatic t_cp;
    st(1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    acc(2'h2, 4'h0, 1'b1, 3'h2);
    chk("np", not_possible, 1'b1);
    chk("np_done", acc_done, 1'b0);
    acc(2'h0, 4'h8, 1'b0, 3'h1);
    acc(2'h1, 4'h1, 1'b0, 3'h1);
    st(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    acc(2'h2, 4'h2, 1'b0, 3'h1);
    chk("undef", undef_exception, 1'b1);
    st(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    acc(2'h2, 4'h2, 1'b0, 3'h4);
    chk("wi_rd", acc_rdata, 32'h1234_5678);
    acc(2'h0, 4'h1, 1'b0, 3'h5);
    chk("raz", acc_rdata, 32'h0);
    acc(2'h0, 4'h6, 1'b0, 3'h3);
  endtask
  task automatic t_lock;
    st(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    acc(2'h1, 4'h0, 1'b1, 3'h4);
    chk("lock_we", acc_write_en, 1'b0);
    acc(2'h3, 4'h0, 1'b1, 3'h0);
    chk("jt_we", acc_write_en, 1'b1);
    acc(2'h3, 4'h8, 1'b1, 3'h1);
    chk("jt_mg", acc_write_en, 1'b0);
    acc(2'h3, 4'h6, 1'b1, 3'h1);
    chk("jt_sr", acc_write_en, 1'b0);
    st(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    acc(2'h3, 4'h0, 1'b1, 3'h1);
    chk("jt_pd", acc_write_en, 1'b0);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_main();
    t_swen();
    t_cp();
    t_lock();
    close_out();
  end
endmodule
bind trap_checker trap_sva u_sva (
  .clk                          (clk),
  .reset                        (reset),
  .acc_valid                    (acc_valid),
  .acc_port                     (acc_port),
  .acc_from_debugger            (acc_from_debugger),
  .acc_class                    (acc_class),
  .acc_write                    (acc_write),
  .unit_powered                 (unit_powered),
  .proc_privileged              (proc_privileged),
  .coproc_access_enabled        (coproc_access_enabled),
  .software_debug_access_enable (software_debug_access_enable),
  .software_lock_set            (software_lock_set),
  .acc_done                     (acc_done),
  .acc_outcome                  (acc_outcome),
  .acc_write_en                 (acc_write_en),
  .mem_bus_error                (mem_bus_error),
  .undef_exception              (undef_exception),
  .not_possible                 (not_possible)
);
`default_nettype wire
